// [dv/fsp_spi_host.sv]
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_host (
	output logic      spiClk,
	output logic      spiCsN,
	output logic      spiDin,
	input  wire logic spiDout
);
	logic [7:0] rdQ[$];
	logic [7:0] sh;

	// Link clock stands low between frames
	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiDin = 1'b1;
		sh = 8'h00;
	end

	// One frame: nb bits out MSB first, then nr bytes in
	task automatic frame(input logic [39:0] bits, input int nb, input int nr);
		rdQ.delete();
		spiCsN = 1'b0;
		#24;
		for (int i = nb - 1; i >= 0; i--) begin
			spiDin = bits[i];
			#24 spiClk = 1'b1;
			#24 spiClk = 1'b0;
		end
		// Released line shows the inverse, never a stale value
		spiDin = ~spiDin;
		for (int b = 0; b < nr; b++) begin
			for (int i = 0; i < 8; i++) begin
				#24 spiClk = 1'b1;
				sh = {sh[6:0], spiDout};
				#24 spiClk = 1'b0;
			end
			rdQ.push_back(sh);
		end
		#24 spiCsN = 1'b1;
		#60;
	endtask : frame
endmodule : fsp_spi_host
`default_nettype wire

// [dv/fsp_status_protect_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module fsp_status_protect_bench import fsp_pkg::*; ;
	`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errCount++; \
		$display("BAD %0t got %h exp %h", $time, a, b); end end
	localparam int WCNT = 40;
	logic       clk_sys, rst, spiClk, spiCsN, spiDin, guardPinN, pausePinN;
	logic       quadActive, sectorMode, inProtArea, arrayBusy, memRdValid;
	logic       memRdReady, arrayReqValid, spiDout, spiDoutEn, pauseActive, doutSeen;
	logic       reqSeen;
	logic [7:0] memData, statusOut, d;
	logic [23:0] memAddr;
	logic [3:0] protBits;
	fsp_req_s   arrayReq;
	int         errCount, nCompared, cycles, seed, mStat;

	// Array model: data is a fixed function of the address
	function automatic logic [7:0] memFn(input logic [23:0] a);
		return a[7:0] ^ a[23:16] ^ 8'h5A;
	endfunction : memFn
	assign memData = memFn(memAddr);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	fsp_status_protect #(.WRITE_CNT(WCNT)) u_dut (.clk_sys(clk_sys), .rst(rst),
		.spiClk(spiClk), .spiCsN(spiCsN), .spiDin(spiDin), .guardPinN(guardPinN),
		.pausePinN(pausePinN), .quadActive(quadActive), .sectorMode(sectorMode),
		.inProtArea(inProtArea), .arrayBusy(arrayBusy), .memData(memData),
		.memRdValid(memRdValid), .memRdReady(memRdReady), .memAddr(memAddr),
		.protBits(protBits), .arrayReq(arrayReq), .arrayReqValid(arrayReqValid),
		.spiDout(spiDout), .spiDoutEn(spiDoutEn), .pauseActive(pauseActive),
		.statusOut(statusOut));
	fsp_spi_host u_host (.spiClk(spiClk), .spiCsN(spiCsN), .spiDin(spiDin),
		.spiDout(spiDout));

	// Memory stalls at random between frames; hang guard
	always @(posedge clk_sys) begin
		memRdReady <= !spiCsN || (($random(seed) & 1) != 0);
		if (spiDoutEn === 1'b1) doutSeen <= 1'b1;
		if (arrayReqValid === 1'b1) reqSeen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles > 40000) begin
			errCount++;
			end_of_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic note(input string s);
		$display("test done: %s", s);
	endtask : note

	// Optional arm, then status write of nb bits; model updated if accepted
	task automatic status_write_cmd(input logic [7:0] v, input int nb, input bit arm, input bit ok);
		if (arm) begin
			u_host.frame(40'(CMD_WRITE_ARM), 8, 0);
			`CHK(statusOut[1], 1'b1)
		end
		u_host.frame(40'({CMD_STATUS_WRITE, v, 1'b1}) >> (17 - nb), nb, 0);
		tick(8);
		`CHK(statusOut[0], ok)
		for (int i = 0; i < 4 * WCNT && statusOut[0] !== 1'b0; i++) tick(1);
		if (ok) mStat = sectorMode ? (mStat | 8'h80) : {v[7:2], 2'b00};
		`CHK(statusOut[7:2], mStat[7:2])
		`CHK(protBits, mStat[5:2])
		if (ok) `CHK(statusOut[1:0], 2'b00)
	endtask : status_write_cmd

	// Plain read of n bytes; ok says whether data must come out
	task automatic rd(input logic [23:0] a, input int n, input bit ok);
		doutSeen = 1'b0;
		u_host.frame(40'({CMD_READ, a}), 32, n);
		`CHK(doutSeen, ok)
		`CHK(spiDoutEn, 1'b0)
		for (int i = 0; ok && i < n; i++)
			`CHK(u_host.rdQ[i], memFn(a + 24'(i)))
	endtask : rd

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		seed = 32'h9f56;
		rst = 1'b1;
		guardPinN = 1'b1;
		pausePinN = 1'b1;
		quadActive = 1'b0;
		sectorMode = 1'b0;
		inProtArea = 1'b0;
		arrayBusy = 1'b0;
		memRdReady = 1'b1;
		doutSeen = 1'b0;
		reqSeen = 1'b0;
		{mStat, cycles, errCount, nCompared} = '0;
		tick(6);
		rst <= 1'b0;
		tick(3);
		`CHK(statusOut, STATUS_RESET)
		status_write_cmd(8'h3C, 16, 0, 0);
		d = 8'($random(seed)) & 8'h7F;
		status_write_cmd(d, 16, 1, 1);
		for (int nb = 15; nb <= 17; nb += 2) status_write_cmd(8'h14, nb, 1, 0);
		note("status write");
		status_write_cmd(8'h00, 16, 1, 1);
		@(posedge clk_sys) pausePinN <= 1'b0;
		tick(6);
		`CHK(pauseActive, 1'b1)
		@(posedge clk_sys) quadActive <= 1'b1;
		tick(6);
		`CHK(pauseActive, 1'b0)
		@(posedge clk_sys) pausePinN <= 1'b1;
		rd(24'h000100, 1, 0);
		@(posedge clk_sys) quadActive <= 1'b0;
		status_write_cmd(8'h40, 16, 1, 1);
		@(posedge clk_sys) pausePinN <= 1'b0;
		tick(6);
		`CHK(pauseActive, 1'b0)
		@(posedge clk_sys) pausePinN <= 1'b1;
		note("pin disable");
		status_write_cmd(8'h80, 16, 1, 1);
		@(posedge clk_sys) guardPinN <= 1'b0;
		status_write_cmd(8'h3C, 16, 1, 0);
		@(posedge clk_sys) guardPinN <= 1'b1;
		status_write_cmd(8'h00, 16, 1, 1);
		note("guard mode");
		reqSeen = 1'b0;
		u_host.frame(40'(CMD_WRITE_ARM), 8, 0);
		u_host.frame(40'(CMD_CHIP_ERASE), 8, 0);
		`CHK(reqSeen, 1'b1)
		`CHK(arrayReq.cmd, CMD_CHIP_ERASE)
		`CHK(statusOut[1], 1'b0)
		status_write_cmd(8'h04, 16, 1, 1);
		reqSeen = 1'b0;
		u_host.frame(40'(CMD_WRITE_ARM), 8, 0);
		u_host.frame(40'(CMD_CHIP_ERASE), 8, 0);
		`CHK(reqSeen, 1'b0)
		status_write_cmd(8'h00, 16, 1, 1);
		note("chip erase");
		rd(24'hFFFFFE, 3, 1);
		rd(24'($random(seed)), 2, 1);
		@(posedge clk_sys) arrayBusy <= 1'b1;
		tick(6);
		`CHK(statusOut[0], 1'b1)
		rd(24'h000010, 1, 0);
		@(posedge clk_sys) arrayBusy <= 1'b0;
		note("read");
		@(posedge clk_sys) sectorMode <= 1'b1;
		status_write_cmd(8'h3C, 16, 1, 1);
		@(posedge clk_sys) sectorMode <= 1'b0;
		note("sector seal");
		end_of_test();
	end
endmodule : fsp_status_protect_bench
`default_nettype wire

// [verilog/fsp_pkg.sv]
package fsp_pkg;

	// Opcodes
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ         = 8'h03;
	localparam logic [7:0] CMD_WRITE_ARM    = 8'h06;
	localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
	localparam logic [7:0] CMD_PAGE_PROG    = 8'h02;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLOCK_ERASE  = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE   = 8'hC7;

	// Status bit positions
	localparam int BIT_BUSY    = 0;
	localparam int BIT_LATCH   = 1;
	localparam int BIT_PROT_LO = 2;
	localparam int BIT_PROT_HI = 5;
	localparam int BIT_PINDIS  = 6;
	localparam int BIT_LOCK    = 7;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [3:0] PROT_NONE    = 4'h0;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	localparam logic [5:0] CYC_ADDR_END = 6'h17;
	localparam logic [5:0] CYC_DATA_END = 6'h0F;
	localparam logic [5:0] CYC_OP_END   = 6'h07;

	// Self-timed status write, in microseconds
	localparam int T_WRITE_US   = 10;
	localparam int CLK_MHZ      = 200;
	localparam int WRITE_CYCLES = T_WRITE_US * CLK_MHZ;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_OP    = 6'b000010,
		ST_ADDR  = 6'b000100,
		ST_DATA  = 6'b001000,
		ST_RDOUT = 6'b010000,
		ST_SKIP  = 6'b100000
	} fsp_state_e;

	// Erase or program request toward the array
	typedef struct packed {
		logic [7:0]  cmd;
		logic [23:0] addr;
	} fsp_req_s;

endpackage : fsp_pkg

// [verilog/fsp_status_protect.sv]
`timescale 1ns/1ps
`default_nettype none
module fsp_status_protect
	import fsp_pkg::*;
#(
	parameter int WRITE_CNT = WRITE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        spiClk,
	input  wire logic        spiCsN,
	input  wire logic        spiDin,
	input  wire logic        guardPinN,
	input  wire logic        pausePinN,
	input  wire logic        quadActive,
	input  wire logic        sectorMode,
	input  wire logic        inProtArea,
	input  wire logic        arrayBusy,
	input  wire logic [7:0]  memData,
	output logic             memRdValid,
	input  wire logic        memRdReady,
	output logic [23:0]      memAddr,
	output logic [3:0]       protBits,
	output fsp_req_s         arrayReq,
	output logic             arrayReqValid,
	output logic             spiDout,
	output logic             spiDoutEn,
	output logic             pauseActive,
	output logic [7:0]       statusOut
);

	// Two-flop synchronisers for the pins
	logic [1:0] clkSync_r, csSync_r, dinSync_r, wpSync_r, holdSync_r;
	logic [1:0] clkSync_nxt, csSync_nxt, dinSync_nxt, wpSync_nxt, holdSync_nxt;
	logic       clkPrev_r, clkPrev_nxt;
	always_comb begin
		clkSync_nxt  = {clkSync_r[0], spiClk};
		csSync_nxt   = {csSync_r[0], spiCsN};
		dinSync_nxt  = {dinSync_r[0], spiDin};
		wpSync_nxt   = {wpSync_r[0], guardPinN};
		holdSync_nxt = {holdSync_r[0], pausePinN};
		clkPrev_nxt  = clkSync_r[1];
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clkSync_r  <= 2'h0;
			csSync_r   <= 2'h3;
			dinSync_r  <= 2'h0;
			wpSync_r   <= 2'h3;
			holdSync_r <= 2'h3;
			clkPrev_r  <= 1'b0;
		end else begin
			clkSync_r  <= clkSync_nxt;
			csSync_r   <= csSync_nxt;
			dinSync_r  <= dinSync_nxt;
			wpSync_r   <= wpSync_nxt;
			holdSync_r <= holdSync_nxt;
			clkPrev_r  <= clkPrev_nxt;
		end
	end

	logic csN, sclkRise, sclkFall, din;
	assign csN      = csSync_r[1];
	assign din      = dinSync_r[1];
	assign sclkRise = clkSync_r[1] & ~clkPrev_r & ~csN;
	assign sclkFall = ~clkSync_r[1] & clkPrev_r & ~csN;

	// Guard pins lose effect when disabled or in quad operation
	logic pinsLive, guardMode;
	assign pinsLive    = ~statusOut[BIT_PINDIS] & ~quadActive;
	assign guardMode   = statusOut[BIT_LOCK] & pinsLive & ~wpSync_r[1];
	assign pauseActive = pinsLive & ~holdSync_r[1];

	// Frame state
	fsp_state_e state_r, state_nxt;
	logic [7:0]  shift_r, shift_nxt, opcode_r, opcode_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic [23:0] addr_r, addr_nxt;
	logic        wrPend_r, wrPend_nxt;
	logic [7:0]  wrData_r, wrData_nxt;
	logic        armPend_r, armPend_nxt, disPend_r, disPend_nxt;
	logic [7:0]  outSh_r, outSh_nxt;
	logic [2:0]  bitCnt_r, bitCnt_nxt;
	logic        dout_r, dout_nxt, doutEn_r, doutEn_nxt;
	logic        bufFull_r, bufFull_nxt;
	logic [7:0]  buf_r, buf_nxt;

	logic csPrev_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) csPrev_r <= 1'b1;
		else csPrev_r <= csN;
	end

	// Status and write cycle state
	logic [7:0]  stat_r, stat_nxt;
	logic [31:0] wcnt_r, wcnt_nxt;
	logic        wBusy_r, wBusy_nxt;
	fsp_req_s    req_r, req_nxt;
	logic        reqV_r, reqV_nxt;
	logic        frameEnd;
	assign frameEnd = csN & ~csPrev_r;

	always_comb begin
		state_nxt  = state_r;
		shift_nxt  = shift_r;
		opcode_nxt = opcode_r;
		cnt_nxt    = cnt_r;
		addr_nxt   = addr_r;
		wrPend_nxt = wrPend_r;
		wrData_nxt = wrData_r;
		armPend_nxt = armPend_r;
		disPend_nxt = disPend_r;
		outSh_nxt  = outSh_r;
		bitCnt_nxt = bitCnt_r;
		dout_nxt   = dout_r;
		doutEn_nxt = doutEn_r;
		bufFull_nxt = bufFull_r;
		buf_nxt    = buf_r;
		stat_nxt   = stat_r;
		wcnt_nxt   = wcnt_r;
		wBusy_nxt  = wBusy_r;
		req_nxt    = req_r;
		reqV_nxt   = 1'b0;
		// Two-entry path: array word to holding buffer to shifter
		if (memRdValid && !bufFull_r) begin
			buf_nxt     = memData;
			bufFull_nxt = 1'b1;
			addr_nxt    = addr_r + 24'h000001;
		end
		if (csN) begin
			state_nxt   = ST_IDLE;
			doutEn_nxt  = 1'b0;
			bufFull_nxt = 1'b0;
			cnt_nxt     = 6'h00;
		end else if (sclkRise) begin
			shift_nxt = {shift_r[6:0], din};
			cnt_nxt   = cnt_r + 6'h01;
			case (state_r)
				ST_IDLE, ST_OP: begin
					state_nxt = ST_OP;
					if (cnt_r == CYC_OP_END) begin
						opcode_nxt = {shift_r[6:0], din};
						cnt_nxt    = 6'h00;
						case ({shift_r[6:0], din})
							CMD_READ:
								state_nxt = (wBusy_r | arrayBusy | quadActive)
									? ST_SKIP : ST_ADDR;
							CMD_STATUS_WRITE, CMD_PAGE_PROG, CMD_SECTOR_ERASE,
							CMD_BLOCK_ERASE:
								state_nxt = ST_ADDR;
							default: state_nxt = ST_SKIP;
						endcase
						if ({shift_r[6:0], din} == CMD_STATUS_WRITE)
							state_nxt = ST_DATA;
						if ({shift_r[6:0], din} == CMD_STATUS_READ) begin
							state_nxt  = ST_RDOUT;
							outSh_nxt  = statusOut;
						end
						armPend_nxt = ({shift_r[6:0], din} == CMD_WRITE_ARM);
						disPend_nxt = ({shift_r[6:0], din} == CMD_WRITE_DIS);
						wrPend_nxt  = 1'b0;
					end else begin
						armPend_nxt = 1'b0;
						disPend_nxt = 1'b0;
					end
				end
				ST_ADDR: begin
					addr_nxt = {addr_r[22:0], din};
					if (cnt_r == CYC_ADDR_END) begin
						state_nxt = (opcode_r == CMD_READ) ? ST_RDOUT : ST_SKIP;
						cnt_nxt   = 6'h00;
						if (opcode_r != CMD_READ) begin
							req_nxt.cmd  = opcode_r;
							req_nxt.addr = {addr_r[22:0], din};
						end
					end
				end
				ST_DATA: begin
					wrData_nxt = {wrData_r[6:0], din};
					wrPend_nxt = (cnt_r == CYC_OP_END);
					if (cnt_r == CYC_OP_END) state_nxt = ST_SKIP;
				end
				ST_RDOUT, ST_SKIP: begin
					wrPend_nxt = 1'b0;
				end
				default: state_nxt = ST_IDLE;
			endcase
		end else if (sclkFall && state_r == ST_RDOUT) begin
			// Shift out on falling edges
			doutEn_nxt = 1'b1;
			dout_nxt   = outSh_r[7];
			outSh_nxt  = {outSh_r[6:0], 1'b0};
			bitCnt_nxt = bitCnt_r + 3'h1;
			// A read byte leaves the buffer on its own first fall, so the
			// fall right after the last address bit already carries data
			if (opcode_r == CMD_READ && bitCnt_r == 3'h0) begin
				dout_nxt    = buf_r[7];
				outSh_nxt   = {buf_r[6:0], 1'b0};
				bufFull_nxt = 1'b0;
			end
			// Status read repeats the live register every byte
			if (opcode_r != CMD_READ && bitCnt_r == BIT_LAST)
				outSh_nxt = statusOut;
		end
		if (csN) bitCnt_nxt = 3'h0;
		// Chip select rise commits arm, disable, status write and erase or program commands
		if (frameEnd) begin
			wrPend_nxt  = 1'b0;
			armPend_nxt = 1'b0;
			disPend_nxt = 1'b0;
			if (armPend_r && !wBusy_r) stat_nxt[BIT_LATCH] = 1'b1;
			if (disPend_r && !wBusy_r) stat_nxt[BIT_LATCH] = 1'b0;
			if (wrPend_r && stat_r[BIT_LATCH] && !wBusy_r && !guardMode) begin
				if (sectorMode) stat_nxt[BIT_LOCK] = 1'b1;
				else stat_nxt[7:2] = wrData_r[7:2];
				wBusy_nxt = 1'b1;
				wcnt_nxt  = 32'h0;
			end
			if (stat_r[BIT_LATCH] && !wBusy_r && state_r == ST_SKIP
				&& req_r.cmd != 8'h00) begin
				reqV_nxt = ~(sectorMode & stat_r[BIT_LOCK]) & ~inProtArea;
				stat_nxt[BIT_LATCH] = 1'b0;
			end
			if (opcode_r == CMD_CHIP_ERASE && cnt_r == 6'h00 && stat_r[BIT_LATCH]
				&& stat_r[BIT_PROT_HI:BIT_PROT_LO] == PROT_NONE) begin
				reqV_nxt = 1'b1;
				req_nxt.cmd = CMD_CHIP_ERASE;
				stat_nxt[BIT_LATCH] = 1'b0;
			end
			req_nxt.cmd = reqV_nxt ? req_nxt.cmd : 8'h00;
		end
		if (wBusy_r) begin
			wcnt_nxt = wcnt_r + 32'h1;
			if (wcnt_r == 32'(WRITE_CNT - 1)) begin
				wBusy_nxt = 1'b0;
				stat_nxt[BIT_LATCH] = 1'b0;
			end
		end
		stat_nxt[BIT_BUSY] = wBusy_nxt | arrayBusy;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE; shift_r <= 8'h00; opcode_r <= 8'h00;
			cnt_r <= 6'h00; addr_r <= 24'h000000; wrPend_r <= 1'b0;
			wrData_r <= 8'h00; armPend_r <= 1'b0; disPend_r <= 1'b0;
			outSh_r <= 8'h00; bitCnt_r <= 3'h0; dout_r <= 1'b0;
			doutEn_r <= 1'b0; bufFull_r <= 1'b0; buf_r <= 8'h00;
			stat_r <= STATUS_RESET; wcnt_r <= 32'h0; wBusy_r <= 1'b0;
			req_r <= '0; reqV_r <= 1'b0;
		end else begin
			state_r <= state_nxt; shift_r <= shift_nxt; opcode_r <= opcode_nxt;
			cnt_r <= cnt_nxt; addr_r <= addr_nxt; wrPend_r <= wrPend_nxt;
			wrData_r <= wrData_nxt; armPend_r <= armPend_nxt; disPend_r <= disPend_nxt;
			outSh_r <= outSh_nxt; bitCnt_r <= bitCnt_nxt; dout_r <= dout_nxt;
			doutEn_r <= doutEn_nxt; bufFull_r <= bufFull_nxt; buf_r <= buf_nxt;
			stat_r <= stat_nxt; wcnt_r <= wcnt_nxt; wBusy_r <= wBusy_nxt;
			req_r <= req_nxt; reqV_r <= reqV_nxt;
		end
	end

	// Array fetch requested when a read frame has buffer room and memRdReady is high
	assign memRdValid    = (state_r == ST_RDOUT) & (opcode_r == CMD_READ) & ~bufFull_r
		& memRdReady & ~csN;
	assign memAddr       = addr_r;
	assign protBits      = stat_r[BIT_PROT_HI:BIT_PROT_LO];
	assign arrayReq      = req_r;
	assign arrayReqValid = reqV_r;
	assign spiDout       = dout_r;
	assign spiDoutEn     = doutEn_r;
	assign statusOut     = stat_r;

	AST_BUSY_TRACK: assert property (@(posedge clk_sys) disable iff (rst)
		wBusy_r |-> stat_r[BIT_BUSY]) else $error("busy flag low in write cycle");
	AST_LATCH_GATE: assert property (@(posedge clk_sys) disable iff (rst)
		(frameEnd && !stat_r[BIT_LATCH] && !wBusy_r) |=> !wBusy_r)
		else $error("write cycle without latch");
	AST_CHIP_ERASE: assert property (@(posedge clk_sys) disable iff (rst)
		(reqV_r && req_r.cmd == CMD_CHIP_ERASE) |-> $past(protBits) == PROT_NONE)
		else $error("chip erase with protection");
	AST_GUARD: assert property (@(posedge clk_sys) disable iff (rst)
		(frameEnd && guardMode && !wBusy_r) |=> !wBusy_r)
		else $error("status write in guard mode");
	AST_SEAL_ONCE: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(stat_r[BIT_LOCK]) |-> !sectorMode) else $error("seal cleared");
	AST_KEEP_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(wBusy_r) |-> stat_r[BIT_LATCH]) else $error("latch lost at start");
	AST_READ_BUSY: assert property (@(posedge clk_sys) disable iff (rst)
		(sclkRise && state_r == ST_OP && cnt_r == CYC_OP_END && wBusy_r
		&& {shift_r[6:0], din} == CMD_READ)
		|=> state_r != ST_ADDR) else $error("read accepted while busy");
	AST_CS_STOP: assert property (@(posedge clk_sys) disable iff (rst)
		csN |=> !spiDoutEn) else $error("output driven after deselect");
	// Arm frame must leave the latch set when no cycle runs
	AST_ARM_SETS: assert property (@(posedge clk_sys) disable iff (rst)
		(frameEnd && armPend_r && !wBusy_r) |=> stat_r[BIT_LATCH])
		else $error("write arm did not set latch");
	// Sector mode write must seal, whatever the data byte held
	AST_SEAL_SET: assert property (@(posedge clk_sys) disable iff (rst)
		(frameEnd && wrPend_r && stat_r[BIT_LATCH] && !wBusy_r && !guardMode
		&& sectorMode) |=> stat_r[BIT_LOCK])
		else $error("sector write did not seal");
	// Top address rolls to zero; a stuck carry would pin the read there
	AST_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
		(memRdValid && !bufFull_r && (&addr_r)) |=> addr_r == '0)
		else $error("read address did not wrap");
	COV_WRITE: cover property (@(posedge clk_sys) $rose(wBusy_r));
	COV_WRAP: cover property (@(posedge clk_sys) memRdValid && (&addr_r));
	COV_CHIP: cover property (@(posedge clk_sys) reqV_r && req_r.cmd == CMD_CHIP_ERASE);
	COV_READ: cover property (@(posedge clk_sys) memRdValid);
	COV_ARM: cover property (@(posedge clk_sys) $rose(stat_r[BIT_LATCH]));

endmodule : fsp_status_protect
`default_nettype wire
